// File: verilog/cirb_pkg.sv
// Purpose: Shared constants and types for the identity register bank.
// Assumes: 16-bit register words addressed by a 16-bit register number.
// Notes: Text areas live in one flat word store, one base per text.
`default_nettype none
package cirb_pkg;
    // Register numbers
    localparam logic [15:0] OFS_ID_SIG = 16'h0000;
    localparam logic [15:0] OFS_DEV_TYPE = 16'h0001;
    localparam logic [15:0] OFS_LINK_TYPE = 16'h0002;
    localparam logic [15:0] OFS_SPARE_A = 16'h0003;
    localparam logic [15:0] OFS_SPARE_B = 16'h0004;
    localparam logic [15:0] OFS_FW_A_MAJ = 16'h0005;
    localparam logic [15:0] OFS_FW_A_MIN = 16'h0006;
    localparam logic [15:0] OFS_FW_B_MAJ = 16'h0007;
    localparam logic [15:0] OFS_FW_B_MIN = 16'h0008;
    localparam logic [15:0] OFS_FW_FB_MAJ = 16'h0009;
    localparam logic [15:0] OFS_FW_FB_MIN = 16'h000a;
    localparam logic [15:0] OFS_WEB_MAJ = 16'h000b;
    localparam logic [15:0] OFS_WEB_MIN = 16'h000c;
    localparam logic [15:0] OFS_U8SN_SIG = 16'h0020;
    localparam logic [15:0] OFS_U8SN_FIRST = 16'h0021;
    localparam logic [15:0] OFS_U8SN_LAST = 16'h0034;
    localparam logic [15:0] OFS_U8NM_SIG = 16'h0040;
    localparam logic [15:0] OFS_U8NM_FIRST = 16'h0041;
    localparam logic [15:0] OFS_U8NM_LAST = 16'h0068;
    localparam logic [15:0] OFS_ASN_SIG = 16'h0080;
    localparam logic [15:0] OFS_ASN_FIRST = 16'h0081;
    localparam logic [15:0] OFS_ASN_LAST = 16'h0085;
    localparam logic [15:0] OFS_ANM_SIG = 16'h00a0;
    localparam logic [15:0] OFS_ANM_FIRST = 16'h00a1;
    localparam logic [15:0] OFS_ANM_LAST = 16'h00aa;
    // Link type codes (02 reserved, 05 upward unassigned)
    localparam logic [7:0] LINK_CODE_TCP = 8'h01;
    localparam logic [7:0] LINK_CODE_RTU = 8'h03;
    localparam logic [7:0] LINK_CODE_RTU_FB = 8'h04;
    // Values after reset
    localparam logic [15:0] SIG_RST = 16'h0000;
    localparam logic [15:0] SPARE_VAL = 16'h0000;
    localparam logic [15:0] TXT_RST = 16'h0000;
    // Text word counts and bases in the flat store
    localparam logic [6:0] U8SN_WORDS = 7'h14;
    localparam logic [6:0] U8NM_WORDS = 7'h28;
    localparam logic [6:0] ASN_WORDS = 7'h05;
    localparam logic [6:0] ANM_WORDS = 7'h0a;
    localparam logic [6:0] U8SN_BASE = 7'h00;
    localparam logic [6:0] U8NM_BASE = U8SN_BASE + U8SN_WORDS;
    localparam logic [6:0] ASN_BASE = U8NM_BASE + U8NM_WORDS;
    localparam logic [6:0] ANM_BASE = ASN_BASE + ASN_WORDS;
    localparam int TXT_WORDS = 75;
    localparam int NUM_SIG = 5;

    // Physical link the server is reached over
    typedef enum logic [1:0] {
        CIRB_LINK_TCP = 2'h0,
        CIRB_LINK_RTU = 2'h1,
        CIRB_LINK_RTU_FB = 2'h2
    } cirb_link_t;

    // Firmware or page version triple
    typedef struct packed {
        logic [7:0] main;
        logic [7:0] sub;
        logic [7:0] patch;
    } cirb_ver_t;

    // One register access from the protocol front end
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } cirb_req_t;

    // Answer to an access
    typedef struct packed {
        logic rd_valid;
        logic wr_ack;
        logic err;
        logic [15:0] data;
    } cirb_rsp_t;

    // Address decode result
    typedef struct packed {
        logic hit;
        logic [6:0] idx;
    } cirb_slot_t;
endpackage
`default_nettype wire

// File: verilog/cirb_bank.sv
// Purpose: Identity and text register bank behind the fieldbus server.
// Assumes: Requests come from same-clock protocol logic, one per cycle.
// Notes: Reads answer one cycle later; signatures count down on read.
//
// Operation
// R1: Signature registers read/write, decrement after read
// R2: Client checks device type before trusting map
// R3: Type code low byte, layout version high
// R4: Link code 01/03/04 low, high zero
// R5: Never report 02 or 05 upward
// R6: Version first word: main low, high zero
// R7: Version second word: patch low, sub high
// R8: Coprocessor version reads zero when absent
// R9: UTF-8 serial spans twenty words, forty bytes
// R10: UTF-8 name spans forty words, eighty bytes
// R11: UTF-8 bytes packed two per register
// R12: ASCII serial spans five words, ten bytes
// R13: ASCII name spans ten words, twenty bytes
// R14: ASCII characters packed two per register
// R15: Protected registers refuse writes before login
// R16: Short text followed by zero terminator
// R17: Client may write then read signature back
// R18: Writes to read-only registers change nothing
`timescale 1ns/1ps
`default_nettype none
module cirb_bank #(
    parameter logic [7:0] DEV_TYPE_CODE = 8'h5a, // Arbitrary value
    parameter logic [7:0] LAYOUT_VERSION = 8'h00,
    parameter logic [4:0] SIG_PW_PROT = 5'h00
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Register access from the server
    input wire cirb_pkg::cirb_req_t req,
    output cirb_pkg::cirb_rsp_t rsp,
    // Identity sources
    input wire cirb_pkg::cirb_link_t link_sel,
    input wire logic fieldbus_fitted,
    input wire cirb_pkg::cirb_ver_t ver_main_cpu_a,
    input wire cirb_pkg::cirb_ver_t ver_main_cpu_b,
    input wire cirb_pkg::cirb_ver_t ver_fieldbus,
    input wire cirb_pkg::cirb_ver_t ver_web_page,
    // Password gate
    input wire logic login_required_flag,
    input wire logic login_ok,
    // Local text loader
    input wire logic txt_we,
    input wire logic [1:0] txt_sel,
    input wire logic [5:0] txt_idx,
    input wire logic [15:0] txt_data
);
    import cirb_pkg::*;

    logic [15:0] sig_ff [NUM_SIG];
    logic [15:0] txt_ff [TXT_WORDS];
    cirb_rsp_t rsp_ff;
    logic [15:0] nxt_rd_data;
    logic rd_hit;
    logic wr_ok;
    logic wr_block;
    cirb_slot_t rd_sig;
    cirb_slot_t rd_txt;
    cirb_slot_t ld_slot;

    // Signature register number to signature index
    function automatic cirb_slot_t sig_slot(input logic [15:0] a);
        cirb_slot_t s;
        s = '0;
        s.hit = 1'b1;
        unique case (a)
            OFS_ID_SIG: s.idx = 7'h00;
            OFS_U8SN_SIG: s.idx = 7'h01;
            OFS_U8NM_SIG: s.idx = 7'h02;
            OFS_ASN_SIG: s.idx = 7'h03;
            OFS_ANM_SIG: s.idx = 7'h04;
            default: s.hit = 1'b0;
        endcase
        return s;
    endfunction

    // Text register number to flat store index
    function automatic cirb_slot_t txt_slot(input logic [15:0] a);
        cirb_slot_t s;
        s = '0;
        if (a >= OFS_U8SN_FIRST && a <= OFS_U8SN_LAST) begin
            s.hit = 1'b1; // [R9]
            s.idx = U8SN_BASE + 7'(a - OFS_U8SN_FIRST);
        end else if (a >= OFS_U8NM_FIRST && a <= OFS_U8NM_LAST) begin
            s.hit = 1'b1; // [R10]
            s.idx = U8NM_BASE + 7'(a - OFS_U8NM_FIRST);
        end else if (a >= OFS_ASN_FIRST && a <= OFS_ASN_LAST) begin
            s.hit = 1'b1; // [R12]
            s.idx = ASN_BASE + 7'(a - OFS_ASN_FIRST);
        end else if (a >= OFS_ANM_FIRST && a <= OFS_ANM_LAST) begin
            s.hit = 1'b1; // [R13]
            s.idx = ANM_BASE + 7'(a - OFS_ANM_FIRST);
        end
        return s;
    endfunction

    // First word of a version pair
    function automatic logic [15:0] ver_hi(input cirb_ver_t v);
        return {8'h00, v.main}; // [R6]
    endfunction

    // Second word of a version pair
    function automatic logic [15:0] ver_lo(input cirb_ver_t v);
        return {v.sub, v.patch}; // [R7]
    endfunction

    // Link code; unknown selections fall back to a valid code
    function automatic logic [7:0] link_code(input cirb_link_t l);
        logic [7:0] c;
        c = LINK_CODE_TCP;
        case (l)
            CIRB_LINK_TCP: c = LINK_CODE_TCP;
            CIRB_LINK_RTU: c = LINK_CODE_RTU;
            CIRB_LINK_RTU_FB: c = LINK_CODE_RTU_FB;
            default: c = LINK_CODE_TCP; // [R5]
        endcase
        return c;
    endfunction

    // Loader section to flat index, with bounds check
    always_comb begin
        ld_slot = '0;
        unique case (txt_sel)
            2'h0: begin
                ld_slot.hit = 7'(txt_idx) < U8SN_WORDS;
                ld_slot.idx = U8SN_BASE + 7'(txt_idx);
            end
            2'h1: begin
                ld_slot.hit = 7'(txt_idx) < U8NM_WORDS;
                ld_slot.idx = U8NM_BASE + 7'(txt_idx);
            end
            2'h2: begin
                ld_slot.hit = 7'(txt_idx) < ASN_WORDS;
                ld_slot.idx = ASN_BASE + 7'(txt_idx);
            end
            2'h3: begin
                ld_slot.hit = 7'(txt_idx) < ANM_WORDS;
                ld_slot.idx = ANM_BASE + 7'(txt_idx);
            end
        endcase
    end

    // Decode of the current access
    assign rd_sig = sig_slot(req.addr);
    assign rd_txt = txt_slot(req.addr);
    // Protected signatures refuse writes while login is required and not yet accepted
    assign wr_block = rd_sig.hit && SIG_PW_PROT[rd_sig.idx[2:0]] &&
                      login_required_flag && !login_ok; // [R15]
    assign wr_ok = req.wr && rd_sig.hit && !wr_block; // [R18]

    // Read data multiplexer
    always_comb begin
        nxt_rd_data = 16'h0000;
        rd_hit = 1'b1;
        if (rd_sig.hit) begin
            // Combined write and read returns the value just written
            nxt_rd_data = wr_ok ? req.wdata
                                : sig_ff[rd_sig.idx[2:0]]; // [R1] [R17]
        end else if (rd_txt.hit) begin
            nxt_rd_data = txt_ff[rd_txt.idx]; // [R11] [R14]
        end else begin
            case (req.addr)
                OFS_DEV_TYPE:
                    nxt_rd_data = {LAYOUT_VERSION, DEV_TYPE_CODE}; // [R3]
                OFS_LINK_TYPE:
                    nxt_rd_data = {8'h00, link_code(link_sel)}; // [R4]
                OFS_SPARE_A: nxt_rd_data = SPARE_VAL;
                OFS_SPARE_B: nxt_rd_data = SPARE_VAL;
                OFS_FW_A_MAJ: nxt_rd_data = ver_hi(ver_main_cpu_a);
                OFS_FW_A_MIN: nxt_rd_data = ver_lo(ver_main_cpu_a);
                OFS_FW_B_MAJ: nxt_rd_data = ver_hi(ver_main_cpu_b);
                OFS_FW_B_MIN: nxt_rd_data = ver_lo(ver_main_cpu_b);
                OFS_FW_FB_MAJ:
                    nxt_rd_data = fieldbus_fitted ?
                                  ver_hi(ver_fieldbus) : 16'h0000; // [R8]
                OFS_FW_FB_MIN:
                    nxt_rd_data = fieldbus_fitted ?
                                  ver_lo(ver_fieldbus) : 16'h0000; // [R8]
                OFS_WEB_MAJ: nxt_rd_data = ver_hi(ver_web_page);
                OFS_WEB_MIN: nxt_rd_data = ver_lo(ver_web_page);
                default: rd_hit = 1'b0;
            endcase
        end
    end

    // Signature registers: write first, then count down after a read
    generate
        for (genvar g = 0; g < NUM_SIG; g++) begin : g_sig
            logic sel;
            logic [15:0] base;
            assign sel = rd_sig.hit && (rd_sig.idx == 7'(g));
            assign base = (sel && wr_ok) ? req.wdata : sig_ff[g];
            always_ff @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    sig_ff[g] <= SIG_RST;
                end else if (sel && req.rd) begin
                    sig_ff[g] <= base - 16'h0001; // [R1]
                end else if (sel && wr_ok) begin
                    sig_ff[g] <= req.wdata; // [R1]
                end
            end
        end
    endgenerate

    // Text store; loading word 0 clears the rest of that text
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < TXT_WORDS; i++) begin
                txt_ff[i] <= TXT_RST;
            end
        end else if (txt_we && ld_slot.hit) begin
            if (txt_idx == 6'h00) begin
                for (int i = 0; i < TXT_WORDS; i++) begin
                    if (7'(i) > ld_slot.idx &&
                        7'(i) < ld_slot.idx + (txt_sel == 2'h0 ? U8SN_WORDS :
                                 txt_sel == 2'h1 ? U8NM_WORDS :
                                 txt_sel == 2'h2 ? ASN_WORDS : ANM_WORDS)) begin
                        txt_ff[i] <= TXT_RST; // [R16]
                    end
                end
            end
            txt_ff[ld_slot.idx] <= txt_data; // [R11] [R14]
        end
    end

    // Answer register: read data, write acknowledge, error flag
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rsp_ff <= '0;
        end else begin
            rsp_ff.rd_valid <= req.rd;
            rsp_ff.wr_ack <= req.wr;
            // Error on unmapped read, refused or read-only write
            rsp_ff.err <= (req.rd && !rd_hit) ||
                          (req.wr && !wr_ok); // [R15] [R18]
            if (req.rd) begin
                rsp_ff.data <= rd_hit ? nxt_rd_data : 16'h0000;
            end
        end
    end

    assign rsp = rsp_ff;
endmodule
`default_nettype wire

// File: testbench/cirb_chk.sv
// Purpose: Port checker for the identity register bank.
// Assumes: One clock, nrst asynchronous and active low.
// Notes: Bound onto every cirb_bank instance.
`timescale 1ns/1ps
`default_nettype none
module cirb_chk #(
    parameter logic [7:0] DEV_TYPE_CODE = 8'h5a,
    parameter logic [7:0] LAYOUT_VERSION = 8'h00
) (
    // Clock, reset and register port
    input wire logic mclk,
    input wire logic nrst,
    input wire cirb_pkg::cirb_req_t req,
    input wire cirb_pkg::cirb_rsp_t rsp,
    // Identity sources
    input wire cirb_pkg::cirb_link_t link_sel,
    input wire logic fieldbus_fitted,
    input wire cirb_pkg::cirb_ver_t ver_main_cpu_a
);
    import cirb_pkg::*;
    // All checks on the rising edge, off during reset
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // Link code that each link selection must report
    function automatic logic [7:0] lc(input cirb_link_t l);
        return l == CIRB_LINK_RTU ? LINK_CODE_RTU :
            l == CIRB_LINK_RTU_FB ? LINK_CODE_RTU_FB : LINK_CODE_TCP;
    endfunction
    chk_read_answer: assert property (
        rsp.rd_valid == $past(req.rd)) else $error("read answer late");
    chk_write_ack: assert property (
        rsp.wr_ack == $past(req.wr)) else $error("write answer late");
    chk_type_word: assert property (
        req.rd && req.addr == OFS_DEV_TYPE |=>
        rsp.data == {LAYOUT_VERSION, DEV_TYPE_CODE})
        else $error("device type word wrong");
    chk_link_code: assert property (
        req.rd && req.addr == OFS_LINK_TYPE |=>
        rsp.data == {8'h00, lc($past(link_sel))})
        else $error("link code wrong");
    chk_ver_major: assert property (
        req.rd && req.addr == OFS_FW_A_MAJ |=>
        rsp.data == {8'h00, $past(ver_main_cpu_a.main)})
        else $error("major version word wrong");
    chk_ver_minor: assert property (
        req.rd && req.addr == OFS_FW_A_MIN |=> rsp.data ==
        {$past(ver_main_cpu_a.sub), $past(ver_main_cpu_a.patch)})
        else $error("minor version word wrong");
    chk_fb_absent: assert property (
        req.rd && req.addr == OFS_FW_FB_MIN && !fieldbus_fitted |=>
        rsp.rd_valid && rsp.data == 16'h0000)
        else $error("absent coprocessor version not zero");
    chk_sig_decrement: assert property (
        req.rd && !req.wr && req.addr == OFS_ID_SIG ##1
        (!req.rd && !req.wr) [*2] ##1 req.rd && !req.wr &&
        req.addr == OFS_ID_SIG |=>
        rsp.data == $past(rsp.data, 3) - 16'h0001)
        else $error("signature did not count down");
    chk_ro_write: assert property (
        req.wr && req.addr == OFS_DEV_TYPE |=> rsp.wr_ack && rsp.err)
        else $error("read-only write not refused");
    // Main scenarios reached
    cov_link_fb: cover property (req.rd && link_sel == CIRB_LINK_RTU_FB);
    cov_combined: cover property (req.rd && req.wr);
    cov_refused: cover property (rsp.wr_ack && rsp.err);
endmodule
bind cirb_bank cirb_chk #(.DEV_TYPE_CODE(DEV_TYPE_CODE),
    .LAYOUT_VERSION(LAYOUT_VERSION)) u_chk (.mclk(mclk), .nrst(nrst),
    .req(req), .rsp(rsp), .link_sel(link_sel),
    .fieldbus_fitted(fieldbus_fitted), .ver_main_cpu_a(ver_main_cpu_a));
`default_nettype wire

// File: testbench/cirb_client.sv
// Purpose: Client model issuing register accesses to the bank.
// Assumes: One access at a time, answer one cycle after it is taken.
// Notes: Request held for the edge that takes it; answer taken one edge on.
`timescale 1ns/1ps
`default_nettype none
module cirb_client (
    // Clock and register port
    input wire logic mclk,
    output cirb_pkg::cirb_req_t req,
    input wire cirb_pkg::cirb_rsp_t rsp
);
    import cirb_pkg::*;
    // Idle until the first access
    initial req = '0;
    // Drive after an edge, release at the taking edge, sample one edge on
    task automatic acc(input logic rd, wr, input logic [15:0] a, d,
        output cirb_rsp_t r);
        @(posedge mclk);
        req <= '{rd, wr, a, d};
        @(posedge mclk);
        req <= '0;
        @(posedge mclk);
        r = rsp; // Answer stands through the cycle after the taking edge
    endtask
endmodule
`default_nettype wire

// File: testbench/tb.sv
// Purpose: Self-checking bench for the identity register bank.
// Assumes: Client model drives the register port.
// Notes: Signature at 0x20 is built as password protected.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import cirb_pkg::*;
    localparam logic [7:0] DT = 8'h3c; // Arbitrary value
    localparam logic [7:0] LV = 8'h02;
    logic mclk, nrst, fb_fit, login_req, login_ok, txt_we;
    cirb_req_t req;
    cirb_rsp_t rsp, r;
    cirb_link_t link_sel;
    cirb_ver_t va, vb, vf, vw;
    logic [1:0] txt_sel;
    logic [5:0] txt_idx;
    logic [15:0] txt_data, seed, w;
    logic [23:0] t;
    logic [15:0] sa [5] = '{16'h0, 16'h20, 16'h40, 16'h80, 16'ha0};
    logic [15:0] tbs [4] = '{16'h21, 16'h41, 16'h81, 16'ha1};
    logic [7:0] lt [4] = '{8'h01, 8'h03, 8'h04, 8'h01};
    int nw [4] = '{20, 40, 5, 10};
    int err_count, samples_checked;
    // Design and client
    cirb_bank #(.DEV_TYPE_CODE(DT), .LAYOUT_VERSION(LV),
        .SIG_PW_PROT(5'h02)) u_dut (.mclk(mclk), .nrst(nrst),
        .req(req), .rsp(rsp), .link_sel(link_sel),
        .fieldbus_fitted(fb_fit), .ver_main_cpu_a(va),
        .ver_main_cpu_b(vb), .ver_fieldbus(vf), .ver_web_page(vw),
        .login_required_flag(login_req), .login_ok(login_ok),
        .txt_we(txt_we), .txt_sel(txt_sel), .txt_idx(txt_idx),
        .txt_data(txt_data));
    cirb_client u_cli (.mclk(mclk), .req(req), .rsp(rsp));
    // Clock
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // Compare and report
    task automatic chk(input string nm, input logic [18:0] s, e);
        samples_checked++;
        if (s !== e) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Pseudo-random source
    function automatic logic [23:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return {seed[7:0], seed};
    endfunction
    // Identity word expected at register a
    function automatic logic [15:0] id_exp(input int a);
        cirb_ver_t v;
        v = a < 7 ? va : a < 9 ? vb : a < 11 ? vf : vw;
        if (a < 5 || (a > 8 && a < 11 && !fb_fit))
            return 16'h0000;
        return a[0] ? {8'h00, v.main} : {v.sub, v.patch};
    endfunction
    // Bus and loader helpers
    task automatic rd(input logic [15:0] a, input logic [18:0] e);
        u_cli.acc(1'b1, 1'b0, a, 16'h0000, r);
        chk("read", r, e);
    endtask
    task automatic wr(input logic [15:0] a, d, input logic [2:0] f);
        u_cli.acc(1'b0, 1'b1, a, d, r);
        chk("write flags", {16'h0, r[18:16]}, {16'h0, f});
    endtask
    task automatic load(input int s, i, input logic [15:0] d);
        @(posedge mclk);
        txt_we <= 1'b1;
        txt_sel <= 2'(s);
        txt_idx <= 6'(i);
        txt_data <= d;
        @(posedge mclk);
        txt_we <= 1'b0;
    endtask
    // Hang guard
    initial begin
        repeat (3000) @(posedge mclk);
        err_count++;
        end_sim();
    end
    // Main sequence
    initial begin
        {nrst, fb_fit, login_req, login_ok, txt_we} = 5'h00;
        link_sel = CIRB_LINK_TCP;
        {va, vb, vf, vw} = '0;
        txt_sel = 2'h0;
        txt_idx = 6'h00;
        txt_data = 16'h0000;
        seed = 16'hfd66;
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        rd(OFS_DEV_TYPE, {3'b100, LV, DT});
        rd(OFS_ID_SIG, {3'b100, 16'h0000});
        rd(OFS_ID_SIG, {3'b100, 16'hffff});
        foreach (sa[k]) begin
            t = rnd();
            u_cli.acc(1'b1, 1'b1, sa[k], t[15:0], r);
            chk("sig echo", r, {3'b110, t[15:0]});
            rd(sa[k], {3'b100, t[15:0] - 16'h0001});
            if (k == 1)
                w = t[15:0] - 16'h0002;
        end
        @(posedge mclk) login_req <= 1'b1;
        wr(OFS_U8SN_SIG, 16'h1234, 3'b011);
        rd(OFS_U8SN_SIG, {3'b100, w});
        @(posedge mclk) login_ok <= 1'b1;
        wr(OFS_U8SN_SIG, 16'h1234, 3'b010);
        rd(OFS_U8SN_SIG, {3'b100, 16'h1234});
        wr(OFS_DEV_TYPE, 16'hffff, 3'b011);
        rd(OFS_DEV_TYPE, {3'b100, LV, DT});
        wr(OFS_ASN_FIRST, 16'h4f6b, 3'b011);
        rd(OFS_ASN_FIRST, {3'b100, 16'h0000});
        for (int l = 0; l < 4; l++) begin
            @(posedge mclk) link_sel <= cirb_link_t'(l);
            rd(OFS_LINK_TYPE, {11'h400, lt[l]});
        end
        repeat (4) begin
            @(posedge mclk);
            t = rnd();
            va <= t;
            fb_fit <= t[0];
            t = rnd();
            vb <= t;
            t = rnd();
            vf <= t;
            t = rnd();
            vw <= t;
            for (int a = 3; a < 13; a++) begin
                u_cli.acc(1'b1, 1'b0, 16'(a), 16'h0000, r);
                chk("ident", r, {3'b100, id_exp(a)});
            end
        end
        foreach (tbs[s]) begin
            t = rnd();
            load(s, 0, t[15:0]);
            rd(tbs[s], {3'b100, t[15:0]});
            t = rnd();
            load(s, nw[s] - 1, t[15:0]);
            load(s, nw[s], 16'hffff);
            w = tbs[s] + 16'(nw[s] - 1);
            rd(w, {3'b100, t[15:0]});
            rd(w + 16'h0001, {3'b101, 16'h0000});
            load(s, 0, 16'h0031);
            rd(w, {3'b100, 16'h0000});
        end
        rd(16'h0010, {3'b101, 16'h0000});
        // Second reset in mid-run: signatures and texts back to zero
        @(posedge mclk) nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        rd(OFS_U8SN_SIG, {3'b100, SIG_RST});
        rd(tbs[3], {3'b100, TXT_RST});
        end_sim();
    end
endmodule
`default_nettype wire
